// ---- rmc_pkg.sv ----
// ==========================================================
// Command codes, layouts and reset values
// ==========================================================
package rmc_pkg;

  // Command codes as seen on the serial bus
  localparam logic [7:0] CMD_RUN_MARGIN = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_SRC = 8'h02;
  localparam logic [7:0] CMD_CHAN_WORD = 8'hD0;
  localparam logic [7:0] CMD_ALL_WORD = 8'hD1;
  localparam logic [7:0] CMD_BYTE_TWO = 8'hD9;
  localparam logic [7:0] CMD_BYTE_THREE = 8'hDA;
  localparam logic [7:0] PAGE_ALL = 8'hFF;

  // Reset values of the nonvolatile image
  localparam logic [7:0] RST_RUN_MARGIN = 8'h00;
  localparam logic [7:0] RST_ON_OFF_SRC = 8'h1E;
  localparam logic [15:0] RST_CHAN_WORD = 16'h0080;
  localparam logic [15:0] RST_ALL_WORD = 16'h0F7B;
  localparam logic [7:0] RST_BYTE_TWO = 8'h00;
  localparam logic [7:0] RST_BYTE_THREE = 8'h00;

  // Writable bits, bits forced to one, and zero fill values
  localparam logic [7:0] RUN_MARGIN_MASK = 8'hFC;
  localparam logic [7:0] ON_OFF_MASK = 8'h1D;
  localparam logic [7:0] ON_OFF_FORCED = 8'h02;
  localparam logic [15:0] CHAN_WORD_MASK = 16'h7FFF;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Field positions of the run/margin byte
  localparam int RUN_FIELD_HI = 7;
  localparam int RUN_FIELD_LO = 6;
  localparam int MARGIN_FIELD_HI = 5;
  localparam int MARGIN_FIELD_LO = 4;
  localparam int FAULT_FIELD_HI = 3;
  localparam int FAULT_FIELD_LO = 2;

  // Bit positions of the on/off source byte
  localparam int SRC_CONTROLLED_ON = 4;
  localparam int SRC_USE_BUS = 3;
  localparam int SRC_USE_PIN = 2;
  localparam int SRC_PIN_FAST_OFF = 0;

  typedef enum logic [1:0]
  {
    RUN_OFF_NOW = 2'b00,
    RUN_SEQ_OFF = 2'b01,
    RUN_SEQ_ON = 2'b10,
    RUN_RESERVED = 2'b11
  } run_state_type;

  typedef enum logic [1:0]
  {
    MARGIN_NOMINAL = 2'b00,
    MARGIN_LOW = 2'b01,
    MARGIN_HIGH = 2'b10,
    MARGIN_RESERVED = 2'b11
  } margin_type;

  typedef enum logic [1:0]
  {
    FAULT_RESERVED_LO = 2'b00,
    FAULT_IGNORE = 2'b01,
    FAULT_NORMAL = 2'b10,
    FAULT_RESERVED_HI = 2'b11
  } fault_type;

  // Legal run/margin combinations for the present bus-use setting
  function automatic logic run_margin_legal(input logic [7:0] value, input logic use_bus);
    logic [1:0] run;
    logic [1:0] mar;
    logic [1:0] flt;
    logic margin_ok;
    run = value[RUN_FIELD_HI:RUN_FIELD_LO];
    mar = value[MARGIN_FIELD_HI:MARGIN_FIELD_LO];
    flt = value[FAULT_FIELD_HI:FAULT_FIELD_LO];
    margin_ok = (mar == MARGIN_NOMINAL) ||
                (((mar == MARGIN_LOW) || (mar == MARGIN_HIGH)) &&
                 ((flt == FAULT_IGNORE) || (flt == FAULT_NORMAL)));
    if (run == RUN_RESERVED)
      run_margin_legal = 1'b0;
    else if (use_bus && (run == RUN_OFF_NOW))
      run_margin_legal = 1'b1;
    else
      run_margin_legal = margin_ok;
  endfunction : run_margin_legal

endpackage : rmc_pkg

// ---- rmc_channel.sv ----
`timescale 1ns/10ps
// ==========================================================
// One channel's on/off and margin decision
// ==========================================================
module rmc_channel
(
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [7:0] run_margin, // Accepted run/margin byte
  input wire logic [7:0] on_off_src, // On/off source byte
  input wire logic run_pin, // Run request pin level
  output logic chan_on, // Channel commanded on
  output logic off_now, // Off without sequencing
  output logic margin_low, // Target is margin low
  output logic margin_high, // Target is margin high
  output logic fault_ignore // Faults and warnings ignored
);

  logic next_chan_on;
  logic next_off_now;
  logic next_margin_low;
  logic next_margin_high;
  logic next_fault_ignore;

  // ==========================================================
  // Decision
  // ==========================================================
  // A byte legal at write time can turn reserved when the source byte changes; then hold
  always_comb
  begin
    logic [1:0] run;
    logic [1:0] mar;
    logic [1:0] flt;
    logic use_bus;
    logic use_pin;
    logic ctrl_on;
    logic bus_on;
    logic want_on;
    logic kill;
    run = run_margin[rmc_pkg::RUN_FIELD_HI:rmc_pkg::RUN_FIELD_LO];
    mar = run_margin[rmc_pkg::MARGIN_FIELD_HI:rmc_pkg::MARGIN_FIELD_LO];
    flt = run_margin[rmc_pkg::FAULT_FIELD_HI:rmc_pkg::FAULT_FIELD_LO];
    use_bus = on_off_src[rmc_pkg::SRC_USE_BUS];
    use_pin = on_off_src[rmc_pkg::SRC_USE_PIN];
    ctrl_on = on_off_src[rmc_pkg::SRC_CONTROLLED_ON];
    bus_on = use_bus && (run == rmc_pkg::RUN_SEQ_ON);
    want_on = !ctrl_on ||
              ((use_bus || use_pin) && (!use_bus || bus_on) && (!use_pin || run_pin));
    kill = ctrl_on && use_bus && (run == rmc_pkg::RUN_OFF_NOW);
    next_chan_on = chan_on;
    next_off_now = off_now;
    next_margin_low = margin_low;
    next_margin_high = margin_high;
    next_fault_ignore = fault_ignore;
    if (rmc_pkg::run_margin_legal(run_margin, use_bus))
    begin
      next_chan_on = want_on;
      // Pin fast-off only matters when the pin is what dropped the request
      next_off_now = !want_on && (kill ||
                     (use_pin && !run_pin && on_off_src[rmc_pkg::SRC_PIN_FAST_OFF]));
      next_margin_low = !kill && (mar == rmc_pkg::MARGIN_LOW);
      next_margin_high = !kill && (mar == rmc_pkg::MARGIN_HIGH);
      next_fault_ignore = !kill && (mar != rmc_pkg::MARGIN_NOMINAL) &&
                          (flt == rmc_pkg::FAULT_IGNORE);
    end
  end

  // Register the decision
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chan_on <= 1'b0;
      off_now <= 1'b0;
      margin_low <= 1'b0;
      margin_high <= 1'b0;
      fault_ignore <= 1'b0;
    end
    else
    begin
      chan_on <= next_chan_on;
      off_now <= next_off_now;
      margin_low <= next_margin_low;
      margin_high <= next_margin_high;
      fault_ignore <= next_fault_ignore;
    end
  end

endmodule : rmc_channel

// ---- run_margin_command_control.sv ----
`timescale 1ns/10ps
// How it works
// - Paged read/write run/margin byte at code 01, reset value 00.
// - Paged read/write on/off source byte at code 02, reset value 1E.
// - Paged word D0 resets 0080; unpaged bytes D9, DA reset 00.
// - Unpaged all-channel word at code D1, reset value 0F7B.
// - Page FF makes a run/margin write reach every channel.
// - Byte fields: run 7:6, margin 5:4, fault 3:2, low pair reads 00.
// - With bus honored: 00 off at once, 10 sequence on, 01 sequence off.
// - Margin field picks nominal, low or high, on and sequenced off; off at once clears it.
// - Margin with fault field 01 ignores faults; 10 keeps normal response.
// - On/off comes from run field and run pin as source byte selects.
// - Bus bit clear: run field ignored, margin and fault fields still act.
// - Source bit 3 decides whether the bus run field is obeyed.
// - Source bit 2 decides whether the run pin must be asserted.
module run_margin_command_control
#(
  parameter int NUM_CHAN = 4 // Number of paged channels
)
(
  input wire logic CLK_SYS, // System clock, 20 MHz
  input wire logic RST_B, // Async reset, active low
  input wire logic CMD_WR, // Write strobe, one cycle
  input wire logic CMD_RD, // Read strobe, one cycle
  input wire logic [7:0] CMD_CODE, // Command code
  input wire logic [7:0] CMD_PAGE, // Current page value
  input wire logic [15:0] CMD_WDATA, // Write data, bytes in low half
  input wire logic [NUM_CHAN-1:0] RUN_PIN, // Run request pins
  output logic [15:0] RD_DATA, // Read data
  output logic RD_VALID, // Read answer pulse
  output logic CMD_ACK, // Write taken pulse
  output logic CMD_NACK, // Request refused pulse
  output logic [NUM_CHAN-1:0] CHAN_ON, // Channel commanded on
  output logic [NUM_CHAN-1:0] CHAN_OFF_NOW, // Off without sequencing
  output logic [NUM_CHAN-1:0] MARGIN_LOW_OUT, // Margin low target
  output logic [NUM_CHAN-1:0] MARGIN_HIGH_OUT, // Margin high target
  output logic [NUM_CHAN-1:0] FAULT_IGNORE_OUT // Faults ignored while margined
);

  localparam int PAGE_W = $clog2(NUM_CHAN > 1 ? NUM_CHAN : 2);

  logic [7:0] run_margin [NUM_CHAN];
  logic [7:0] on_off_src [NUM_CHAN];
  logic [15:0] chan_word [NUM_CHAN];
  logic [15:0] all_word;
  logic [7:0] byte_two;
  logic [7:0] byte_three;
  logic [7:0] next_run_margin [NUM_CHAN];
  logic [7:0] next_on_off_src [NUM_CHAN];
  logic [15:0] next_chan_word [NUM_CHAN];
  logic [15:0] next_all_word;
  logic [7:0] next_byte_two;
  logic [7:0] next_byte_three;
  logic [15:0] next_rd_data;
  logic next_rd_valid;
  logic next_ack;
  logic next_nack;

  logic page_all;
  logic page_one;
  logic [PAGE_W-1:0] page_idx;
  logic [NUM_CHAN-1:0] page_sel;

  // Command class and shaped write data
  logic code_known;
  logic code_paged;
  logic page_ok;
  logic [7:0] rm_value;
  logic [7:0] src_value;
  logic [NUM_CHAN-1:0] rm_legal;

  // ==========================================================
  // Page decode
  // ==========================================================
  // Out-of-range pages are refused rather than aliased onto a channel
  always_comb
  begin
    page_all = (CMD_PAGE == rmc_pkg::PAGE_ALL);
    page_one = (CMD_PAGE < 8'(NUM_CHAN));
    page_idx = page_one ? CMD_PAGE[PAGE_W-1:0] : '0;
    // Global page reaches every channel at once
    for (int i = 0; i < NUM_CHAN; i++)
      page_sel[i] = page_all || (page_one && (page_idx == PAGE_W'(i)));
  end

  // ==========================================================
  // Command decode
  // ==========================================================
  // Paged codes need a channel or the global page; unpaged ones take any page
  always_comb
  begin
    code_known = 1'b1;
    code_paged = 1'b0;
    unique case (CMD_CODE)
      rmc_pkg::CMD_RUN_MARGIN,
      rmc_pkg::CMD_ON_OFF_SRC,
      rmc_pkg::CMD_CHAN_WORD:
        code_paged = 1'b1;
      rmc_pkg::CMD_ALL_WORD,
      rmc_pkg::CMD_BYTE_TWO,
      rmc_pkg::CMD_BYTE_THREE:
        code_paged = 1'b0;
      default:
        code_known = 1'b0;
    endcase
    page_ok = code_known && (!code_paged || page_all || page_one);
  end

  // ==========================================================
  // Write data shaping
  // ==========================================================
  // Legality is judged against each channel's own bus-use bit, so a global
  // write may land on some channels and be refused on others
  always_comb
  begin
    rm_value = CMD_WDATA[7:0] & rmc_pkg::RUN_MARGIN_MASK;
    src_value = (CMD_WDATA[7:0] & rmc_pkg::ON_OFF_MASK) | rmc_pkg::ON_OFF_FORCED;
    for (int i = 0; i < NUM_CHAN; i++)
      rm_legal[i] = rmc_pkg::run_margin_legal(rm_value, on_off_src[i][rmc_pkg::SRC_USE_BUS]);
  end

  // ==========================================================
  // Register writes and read answers
  // ==========================================================
  always_comb
  begin
    logic any_taken;
    logic all_taken;
    logic hit;
    // Every register holds and no answer goes out unless a strobe says so
    any_taken = 1'b0;
    all_taken = 1'b1;
    hit = 1'b0;
    next_all_word = all_word;
    next_byte_two = byte_two;
    next_byte_three = byte_three;
    // Read data stands until the next read answer
    next_rd_data = RD_DATA;
    next_rd_valid = 1'b0;
    next_ack = 1'b0;
    next_nack = 1'b0;
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      next_run_margin[i] = run_margin[i];
      next_on_off_src[i] = on_off_src[i];
      next_chan_word[i] = chan_word[i];
    end
    // A write answers with exactly one of acknowledge or refusal
    if (CMD_WR)
    begin
      unique case (CMD_CODE)
        rmc_pkg::CMD_RUN_MARGIN:
        begin
          hit = page_ok;
          for (int i = 0; i < NUM_CHAN; i++)
          begin
            if (page_sel[i])
            begin
              if (rm_legal[i])
              begin
                next_run_margin[i] = rm_value;
                any_taken = 1'b1;
              end
              else
                all_taken = 1'b0;
            end
          end
          hit = hit && any_taken && all_taken;
        end
        rmc_pkg::CMD_ON_OFF_SRC:
        begin
          hit = page_ok;
          for (int i = 0; i < NUM_CHAN; i++)
            if (page_sel[i])
              next_on_off_src[i] = src_value;
        end
        rmc_pkg::CMD_CHAN_WORD:
        begin
          hit = page_ok;
          for (int i = 0; i < NUM_CHAN; i++)
            if (page_sel[i])
              next_chan_word[i] = CMD_WDATA & rmc_pkg::CHAN_WORD_MASK;
        end
        // Unpaged registers take the write whatever the page holds
        rmc_pkg::CMD_ALL_WORD:
        begin
          hit = 1'b1;
          next_all_word = CMD_WDATA;
        end
        rmc_pkg::CMD_BYTE_TWO:
        begin
          hit = 1'b1;
          next_byte_two = CMD_WDATA[7:0];
        end
        rmc_pkg::CMD_BYTE_THREE:
        begin
          hit = 1'b1;
          next_byte_three = CMD_WDATA[7:0];
        end
        default:
          hit = 1'b0;
      endcase
      next_ack = hit;
      next_nack = !hit;
    end
    else if (CMD_RD)
    begin
      // Paged reads with the global page answer from the first channel
      next_rd_valid = 1'b1;
      hit = 1'b1;
      unique case (CMD_CODE)
        rmc_pkg::CMD_RUN_MARGIN:
          next_rd_data = {rmc_pkg::ZERO_BYTE, run_margin[page_idx]};
        rmc_pkg::CMD_ON_OFF_SRC:
          next_rd_data = {rmc_pkg::ZERO_BYTE, on_off_src[page_idx]};
        rmc_pkg::CMD_CHAN_WORD:
          next_rd_data = chan_word[page_idx];
        rmc_pkg::CMD_ALL_WORD:
          next_rd_data = all_word;
        rmc_pkg::CMD_BYTE_TWO:
          next_rd_data = {rmc_pkg::ZERO_BYTE, byte_two};
        rmc_pkg::CMD_BYTE_THREE:
          next_rd_data = {rmc_pkg::ZERO_BYTE, byte_three};
        default:
          hit = 1'b0;
      endcase
      // A paged code on an unknown page is refused like an unmapped one
      if (!page_ok)
        hit = 1'b0;
      // Refused reads answer zero so stale data never looks valid
      if (!hit)
        next_rd_data = rmc_pkg::ZERO_WORD;
      next_nack = !hit;
    end
  end

  // ==========================================================
  // Storage
  // ==========================================================
  // Nonvolatile recall is modelled as the reset value
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        run_margin[i] <= rmc_pkg::RST_RUN_MARGIN;
        on_off_src[i] <= rmc_pkg::RST_ON_OFF_SRC;
        chan_word[i] <= rmc_pkg::RST_CHAN_WORD;
      end
      all_word <= rmc_pkg::RST_ALL_WORD;
      byte_two <= rmc_pkg::RST_BYTE_TWO;
      byte_three <= rmc_pkg::RST_BYTE_THREE;
      // Answer outputs start quiet
      RD_DATA <= rmc_pkg::ZERO_WORD;
      RD_VALID <= 1'b0;
      CMD_ACK <= 1'b0;
      CMD_NACK <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        run_margin[i] <= next_run_margin[i];
        on_off_src[i] <= next_on_off_src[i];
        chan_word[i] <= next_chan_word[i];
      end
      all_word <= next_all_word;
      byte_two <= next_byte_two;
      byte_three <= next_byte_three;
      // Answer pulses and read data
      RD_DATA <= next_rd_data;
      RD_VALID <= next_rd_valid;
      CMD_ACK <= next_ack;
      CMD_NACK <= next_nack;
    end
  end

  // ==========================================================
  // Per-channel decision
  // ==========================================================
  // With the bus bit clear the channel ignores the run field, keeping margin
  // Each channel registers its own decision, so every output leaves a flip-flop
  for (genvar g = 0; g < NUM_CHAN; g++)
  begin : g_chan
    rmc_channel u_chan
    (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .run_margin(run_margin[g]),
      .on_off_src(on_off_src[g]),
      .run_pin(RUN_PIN[g]),
      .chan_on(CHAN_ON[g]),
      .off_now(CHAN_OFF_NOW[g]),
      .margin_low(MARGIN_LOW_OUT[g]),
      .margin_high(MARGIN_HIGH_OUT[g]),
      .fault_ignore(FAULT_IGNORE_OUT[g])
    );
  end

endmodule : run_margin_command_control

// ---- rmc_monitor.sv ----
`timescale 1ns/10ps
// ==========================================
// Register port and channel output checks
// ==========================================
module rmc_monitor
#(
  parameter int NUM_CHAN = 4 // Channel count
)
(
  input wire logic CLK_SYS, // Clock
  input wire logic RST_B, // Reset, active low
  input wire logic CMD_WR, // Write strobe
  input wire logic CMD_RD, // Read strobe
  input wire logic [7:0] CMD_CODE, // Code
  input wire logic [15:0] RD_DATA, // Read data
  input wire logic RD_VALID, // Read answer
  input wire logic CMD_ACK, // Write taken
  input wire logic CMD_NACK, // Refused
  input wire logic [NUM_CHAN-1:0] CHAN_ON, // On
  input wire logic [NUM_CHAN-1:0] CHAN_OFF_NOW, // Off now
  input wire logic [NUM_CHAN-1:0] MARGIN_LOW_OUT, // Low
  input wire logic [NUM_CHAN-1:0] MARGIN_HIGH_OUT, // High
  input wire logic [NUM_CHAN-1:0] FAULT_IGNORE_OUT // Ignore
);
  // One clock domain, so one default for all
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);
  sequence s_wr;
    CMD_WR;
  endsequence
  sequence s_rd;
    CMD_RD && !CMD_WR;
  endsequence
  sequence s_rd_code(logic [7:0] c);
    s_rd ##0 (CMD_CODE == c);
  endsequence
  chk_wr_answer: assert property (s_wr |=> CMD_ACK != CMD_NACK)
    else $error("write got no single answer");
  chk_rd_answer: assert property (s_rd |=> RD_VALID && !CMD_ACK)
    else $error("read got no answer");
  chk_valid_cause: assert property (RD_VALID |-> $past(CMD_RD) && !$past(CMD_WR))
    else $error("read answer without read");
  chk_unmapped_nack: assert property (s_rd ##0 !(CMD_CODE inside {8'h01, 8'h02, 8'hD0, 8'hD1, 8'hD9, 8'hDA})
    |=> CMD_NACK && RD_DATA == 16'h0000)
    else $error("unmapped read not refused");
  chk_rm_low_bits: assert property (s_rd_code(8'h01) |=> RD_DATA[1:0] == 2'b00 && RD_DATA[15:8] == 8'h00)
    else $error("run byte low bits not zero");
  chk_src_fixed: assert property (s_rd_code(8'h02) |=> CMD_NACK || RD_DATA[7:0] ==? 8'b000?_??1?)
    else $error("source byte fixed bits wrong");
  chk_on_off_excl: assert property ((CHAN_ON & CHAN_OFF_NOW) == '0)
    else $error("channel both on and off now");
  chk_margin_excl: assert property ((MARGIN_LOW_OUT & MARGIN_HIGH_OUT) == '0)
    else $error("both margins selected");
  chk_ignore_margin: assert property ((FAULT_IGNORE_OUT & ~(MARGIN_LOW_OUT | MARGIN_HIGH_OUT)) == '0)
    else $error("faults ignored without margin");
endmodule : rmc_monitor

bind run_margin_command_control rmc_monitor #(.NUM_CHAN(NUM_CHAN)) mon_u (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
  .CMD_WR(CMD_WR), .CMD_RD(CMD_RD), .CMD_CODE(CMD_CODE), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
  .CMD_ACK(CMD_ACK), .CMD_NACK(CMD_NACK), .CHAN_ON(CHAN_ON), .CHAN_OFF_NOW(CHAN_OFF_NOW),
  .MARGIN_LOW_OUT(MARGIN_LOW_OUT), .MARGIN_HIGH_OUT(MARGIN_HIGH_OUT), .FAULT_IGNORE_OUT(FAULT_IGNORE_OUT));

// ---- rmc_host_model.sv ----
`timescale 1ns/10ps
// ==========================================
// Host issuing register requests
// ==========================================
module rmc_host_model
#(
  parameter int OFF_GAP = 4 // Cycles kept between off and on
)
(
  input wire logic clk, // Clock
  output logic wr, // Write strobe
  output logic rd, // Read strobe
  output logic [7:0] code, // Code
  output logic [7:0] page, // Page
  output logic [15:0] wdata, // Write data
  input wire logic ack, // Taken
  input wire logic nack, // Refused
  input wire logic valid, // Read answer
  input wire logic [15:0] rdata // Read data
);
  // Idle values from time zero
  initial
  begin
    wr = 1'b0;
    rd = 1'b0;
    code = 8'h00;
    page = 8'h00;
    wdata = 16'h0000;
  end
  // One request; the answer pulse lasts a cycle, so look at once
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] p, input logic [15:0] d,
    output logic n, output logic [15:0] q, output logic t);
    int i;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    code <= c;
    page <= p;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    t = 1'b1;
    n = 1'b0;
    q = 16'h0000;
    for (i = 0; i < 4; i++)
    begin
      #1;
      if ((ack | nack | valid) === 1'b1)
      begin
        n = nack;
        q = rdata;
        t = 1'b0;
        break;
      end
      @(posedge clk);
    end
  endtask : xfer
  // Quiet spell between turning off and back on
  task automatic gap();
    repeat (OFF_GAP) @(posedge clk);
  endtask : gap
endmodule : rmc_host_model

// ---- test_run_margin_command_control.sv ----
`timescale 1ns/10ps
// ==========================================
// Bench
// ==========================================
module test_run_margin_command_control;
  localparam int NC = 4;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic wr, rd, rd_valid, ack, nack;
  logic [7:0] code, page;
  logic [15:0] wdata, rd_data;
  logic [NC-1:0] pins = '0;
  logic [NC-1:0] on, offn, mlo, mhi, fig;
  int miscompares = 0;
  int n_tests = 0;
  // Clock, 50 ns period
  always #25 clk_sys = ~clk_sys;
  run_margin_command_control #(.NUM_CHAN(NC)) dut_u (.CLK_SYS(clk_sys), .RST_B(rst_b), .CMD_WR(wr),
    .CMD_RD(rd), .CMD_CODE(code), .CMD_PAGE(page), .CMD_WDATA(wdata), .RUN_PIN(pins), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .CMD_ACK(ack), .CMD_NACK(nack), .CHAN_ON(on), .CHAN_OFF_NOW(offn),
    .MARGIN_LOW_OUT(mlo), .MARGIN_HIGH_OUT(mhi), .FAULT_IGNORE_OUT(fig));
  rmc_host_model host_u (.clk(clk_sys), .wr(wr), .rd(rd), .code(code), .page(page), .wdata(wdata),
    .ack(ack), .nack(nack), .valid(rd_valid), .rdata(rd_data));
  task automatic check16(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check16
  task automatic checkch(input logic [NC-1:0] g, input logic [NC-1:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error at %0t: channels %b expected %b", $time, g, e);
    end
  endtask : checkch
  task automatic end_of_test();
    $display("Counts: %0d mismatches in %0d checks", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // Request with refusal check; a lost answer ends the run
  task automatic xf(input logic w, input logic [7:0] c, input logic [7:0] p, input logic [15:0] d,
    input logic en, output logic [15:0] q);
    logic n, t;
    host_u.xfer(w, c, p, d, n, q, t);
    check16({15'h0000, n}, {15'h0000, en});
    if (t)
    begin
      miscompares++;
      $display("Error at %0t: no answer", $time);
      end_of_test();
    end
  endtask : xf
  task automatic wrc(input logic [7:0] c, input logic [7:0] p, input logic [15:0] d, input logic en);
    logic [15:0] q;
    xf(1'b1, c, p, d, en, q);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : wrc
  task automatic rdc(input logic [7:0] c, input logic [7:0] p, input logic [15:0] e, input logic en);
    logic [15:0] q;
    xf(1'b0, c, p, 16'h0000, en, q);
    check16(q, e);
  endtask : rdc
  task automatic outs(input logic [NC-1:0] a, b, c, d, e);
    checkch(on, a);
    checkch(offn, b);
    checkch(mlo, c);
    checkch(mhi, d);
    checkch(fig, e);
  endtask : outs
  task automatic pin_set(input logic [NC-1:0] v);
    @(posedge clk_sys);
    pins <= v;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : pin_set
  // Reset values, access kinds and refusals
  task automatic s_defaults();
    logic [7:0] cd [6] = '{8'h01, 8'h02, 8'hD0, 8'hD1, 8'hD9, 8'hDA};
    logic [15:0] ex [6] = '{16'h0000, 16'h001E, 16'h0080, 16'h0F7B, 16'h0000, 16'h0000};
    outs('0, '1, '0, '0, '0);
    foreach (cd[i]) rdc(cd[i], 8'h02, ex[i], 1'b0);
    wrc(8'hD1, 8'h00, 16'h1234, 1'b0);
    rdc(8'hD1, 8'h03, 16'h1234, 1'b0);
    wrc(8'hD0, 8'h01, 16'hFFFF, 1'b0);
    rdc(8'hD0, 8'h01, 16'h7FFF, 1'b0);
    rdc(8'hD0, 8'h00, 16'h0080, 1'b0);
    wrc(8'hD0, 8'hFF, 16'h8001, 1'b0);
    rdc(8'hD0, 8'hFF, 16'h0001, 1'b0);
    rdc(8'hD0, 8'h03, 16'h0001, 1'b0);
    wrc(8'h02, 8'h07, 16'h0000, 1'b1);
    rdc(8'h03, 8'h00, 16'h0000, 1'b1);
    rdc(8'h01, 8'h05, 16'h0000, 1'b1);
  endtask : s_defaults
  // Bus run field with margins, globals and reserved bytes
  task automatic s_bus();
    wrc(8'h02, 8'hFF, 16'h0018, 1'b0);
    rdc(8'h02, 8'h02, 16'h001A, 1'b0);
    wrc(8'h01, 8'hFF, 16'h0080, 1'b0);
    outs('1, '0, '0, '0, '0);
    wrc(8'h01, 8'h00, 16'h009B, 1'b0);
    outs('1, '0, 4'b0001, '0, '0);
    rdc(8'h01, 8'h00, 16'h0098, 1'b0);
    rdc(8'h01, 8'h01, 16'h0080, 1'b0);
    wrc(8'h01, 8'h01, 16'h00A4, 1'b0);
    outs('1, '0, 4'b0001, 4'b0010, 4'b0010);
    wrc(8'h01, 8'hFF, 16'h0040, 1'b0);
    outs('0, '0, '0, '0, '0);
    wrc(8'h01, 8'h00, 16'h00C0, 1'b1);
    wrc(8'h01, 8'h00, 16'h0090, 1'b1);
    rdc(8'h01, 8'h00, 16'h0040, 1'b0);
    wrc(8'h01, 8'hFF, 16'h0054, 1'b0);
    outs('0, '0, '1, '0, '1);
    wrc(8'h01, 8'hFF, 16'h000C, 1'b0);
    outs('0, '1, '0, '0, '0);
  endtask : s_bus
  // Pin combined with bus, then pin alone
  task automatic s_pin();
    wrc(8'h02, 8'hFF, 16'h001C, 1'b0);
    host_u.gap();
    wrc(8'h01, 8'hFF, 16'h0080, 1'b0);
    pin_set(4'b0101);
    outs(4'b0101, '0, '0, '0, '0);
    wrc(8'h02, 8'hFF, 16'h0014, 1'b0);
    wrc(8'h01, 8'hFF, 16'h0000, 1'b0);
    pin_set(4'b0011);
    outs(4'b0011, '0, '0, '0, '0);
    wrc(8'h01, 8'hFF, 16'h0054, 1'b0);
    outs(4'b0011, '0, '1, '0, '1);
    wrc(8'h02, 8'hFF, 16'h0015, 1'b0);
    outs(4'b0011, 4'b1100, '1, '0, '1);
  endtask : s_pin
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1;
    s_defaults();
    s_bus();
    s_pin();
    end_of_test();
  end
endmodule : test_run_margin_command_control
